// ---- design/fcsr_pkg.sv ----
// shared constants and types of the four channel sensor readout
package fcsr_pkg;

   localparam int NUM_CH = 4;

   // system clock rate and the change notification pulse
   localparam int CLK_MHZ = 125;
   localparam int NOTE_PULSE_NS = 1000;
   localparam int NOTE_PULSE_CYC = (NOTE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int NOTE_CNT_W = 7;
   localparam logic [NOTE_CNT_W-1:0] NOTE_LOAD = NOTE_CNT_W'(NOTE_PULSE_CYC - 1);
   localparam logic [NOTE_CNT_W-1:0] NOTE_CNT_RST = 7'h00;

   // cycles after reset during which state differences raise no notification
   localparam int SETTLE_CYC = 4;
   localparam logic [2:0] SETTLE_LOAD = 3'(SETTLE_CYC);

   // serial bit positions and values after reset
   localparam int FIRST_BIT = 0;
   localparam int LAST_BIT = 3;
   localparam logic [3:0] STATE_RST = 4'h0;

   // comparator outputs of one channel, both threshold pairs
   typedef struct packed {
      logic sup_below_lo;
      logic sup_above_hi;
      logic gnd_below_lo;
      logic gnd_above_hi;
   } fcsr_thr_t;

   typedef logic [NUM_CH-1:0] fcsr_state_t;

   // every pin that is brought into the system clock domain
   typedef struct packed {
      logic cs_n;
      logic strobe;
      logic [NUM_CH-1:0] mode;
      fcsr_thr_t [NUM_CH-1:0] thr;
   } fcsr_pins_t;

   // chip select idle high, everything else low
   localparam fcsr_pins_t PINS_RST = 22'h20_0000;

   typedef enum logic [1:0] {
      NOTE_IDLE = 2'h1,
      NOTE_PULSE = 2'h2
   } fcsr_note_t;

endpackage

// ---- design/fcsr_spi_shift.sv ----
// serial shifter of the readout, clocked by the serial clock
module fcsr_spi_shift
   import fcsr_pkg::*;
(
   // serial pins
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   // snapshot frozen in the system domain while chip select is low
   input wire fcsr_state_t i_snap,
   // serial data output and its enable
   output logic o_so,
   output logic o_so_oe
);

   logic si_r;
   logic si_nxt;
   logic shifted_r;
   logic shifted_nxt;
   fcsr_state_t shreg_r;
   fcsr_state_t shreg_nxt;
   fcsr_state_t base;
   logic [2:0] nfall_r;

   always_comb
   begin
      si_nxt = i_si;
      shifted_nxt = 1'b1;
      base = shifted_r ? shreg_r : i_snap;
      // shift towards bit one, chain input enters at bit four
      shreg_nxt = {si_r, base[LAST_BIT:1]};
   end

   // input sampled on the rising edge
   always_ff @(posedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
         si_r <= 1'b0;
      else
         si_r <= si_nxt;
   end

   // output changes on the falling edge
   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         shifted_r <= 1'b0;
         shreg_r <= STATE_RST;
      end
      else
      begin
         shifted_r <= shifted_nxt;
         shreg_r <= shreg_nxt;
      end
   end

   // bit one shows as soon as chip select falls, before any clock edge
   assign o_so = shifted_r ? shreg_r[FIRST_BIT] : i_snap[FIRST_BIT];
   assign o_so_oe = !i_cs_n;

   // helper: falling edges seen in this frame, saturating
   always_ff @(negedge i_sck or posedge i_cs_n)
   begin
      if (i_cs_n)
         nfall_r <= 3'h0;
      else if (nfall_r != 3'h4)
         nfall_r <= nfall_r + 3'h1;
   end

   AST_BIT_ORDER: assert property (@(negedge i_sck) disable iff (i_cs_n)
      (nfall_r < 3'h4) |-> (o_so == i_snap[nfall_r[1:0]]))
      else $error("serial bit does not follow channel order");

   AST_CHAIN_THROUGH: assert property (@(negedge i_sck) disable iff (i_cs_n)
      (nfall_r == 3'h4) |-> (o_so == $past(si_r, 4)))
      else $error("chained bit did not reach output after four shifts");

endmodule

// ---- design/fcsr_top.sv ----
// four channel discrete sensor readout: hysteresis, notification, serial and parallel out
module fcsr_top
   import fcsr_pkg::*;
(
   // system clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SRST,
   // channel comparators and mode selects
   input wire fcsr_thr_t [NUM_CH-1:0] I_CHANNEL_THR,
   input wire logic [NUM_CH-1:0] I_CHANNEL_MODE_SELECT,
   // serial link
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   output logic O_SO,
   output logic O_SO_OE,
   // parallel readout
   input wire logic I_PARALLEL_STROBE,
   output logic [NUM_CH-1:0] O_PARALLEL_STATE_OUT,
   output logic O_PARALLEL_STATE_OE,
   // open-drain change notification
   output logic O_CHANGE_NOTIFY_N_O,
   output logic O_CHANGE_NOTIFY_OE
);

   // next state of one channel from its comparators
   function automatic logic hyst_next(
      input logic mode,
      input fcsr_thr_t thr,
      input logic cur
   );
      logic above;
      logic below;
      above = mode ? thr.sup_above_hi : thr.gnd_above_hi;
      below = mode ? thr.sup_below_lo : thr.gnd_below_lo;
      if (above)
         return 1'b1;
      else if (below)
         return 1'b0;
      else
         return cur;
   endfunction

   // ---- pin synchronisers
   fcsr_pins_t pins_raw;
   fcsr_pins_t sync1_r;
   fcsr_pins_t sync2_r;

   always_comb
   begin
      pins_raw.cs_n = I_CS_N;
      pins_raw.strobe = I_PARALLEL_STROBE;
      pins_raw.mode = I_CHANNEL_MODE_SELECT;
      pins_raw.thr = I_CHANNEL_THR;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         sync1_r <= PINS_RST;
         sync2_r <= PINS_RST;
      end
      else
      begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
      end
   end

   // ---- channel states with hysteresis
   fcsr_state_t state_r;
   fcsr_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
         state_nxt[ch] = hyst_next(sync2_r.mode[ch], sync2_r.thr[ch], state_r[ch]);
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
         state_r <= STATE_RST;
      else
         state_r <= state_nxt;
   end

   // ---- change detection and notification pulse
   // a fresh reset holds notification off until the synchronised inputs have
   // reached the states, so power-up does not look like a change
   fcsr_state_t prev_r;
   fcsr_state_t prev_nxt;
   logic [2:0] settle_r;
   logic [2:0] settle_nxt;
   fcsr_note_t note_r;
   fcsr_note_t note_nxt;
   logic [NOTE_CNT_W-1:0] cnt_r;
   logic [NOTE_CNT_W-1:0] cnt_nxt;
   logic armed;
   logic changed;

   assign armed = (settle_r == 3'h0);
   assign changed = armed && (state_r != prev_r);

   always_comb
   begin
      prev_nxt = state_r;
      settle_nxt = armed ? settle_r : settle_r - 3'h1;
      note_nxt = note_r;
      cnt_nxt = cnt_r;
      unique case (note_r)
         NOTE_IDLE:
         begin
            if (changed)
            begin
               note_nxt = NOTE_PULSE;
               cnt_nxt = NOTE_LOAD;
            end
         end
         NOTE_PULSE:
         begin
            if (changed)
               cnt_nxt = NOTE_LOAD;
            else if (cnt_r == NOTE_CNT_RST)
               note_nxt = NOTE_IDLE;
            else
               cnt_nxt = cnt_r - 7'h01;
         end
         default:
         begin
            note_nxt = NOTE_IDLE;
            cnt_nxt = NOTE_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         prev_r <= STATE_RST;
         settle_r <= SETTLE_LOAD;
         note_r <= NOTE_IDLE;
         cnt_r <= NOTE_CNT_RST;
      end
      else
      begin
         prev_r <= prev_nxt;
         settle_r <= settle_nxt;
         note_r <= note_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // open drain: only ever pulls low
   assign O_CHANGE_NOTIFY_N_O = 1'b0;
   assign O_CHANGE_NOTIFY_OE = (note_r == NOTE_PULSE);

   // ---- snapshot for the serial path
   // the snapshot tracks the states while chip select is high and freezes on
   // its synchronised fall; the serial side first clocks it at least 100 ns
   // later, well after the freeze, so it is static whenever it is sampled
   fcsr_state_t snap_r;
   fcsr_state_t snap_nxt;

   always_comb
   begin
      snap_nxt = sync2_r.cs_n ? state_r : snap_r;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
         snap_r <= STATE_RST;
      else
         snap_r <= snap_nxt;
   end

   // ---- serial shifter in the serial clock domain
   fcsr_spi_shift u_shift (
      .i_sck(I_SCK),
      .i_cs_n(I_CS_N),
      .i_si(I_SI),
      .i_snap(snap_r),
      .o_so(O_SO),
      .o_so_oe(O_SO_OE)
   );

   // ---- parallel readout
   // outputs come from a duplicate of the state flops, loaded with the same next state; the strobe only qualifies
   fcsr_state_t par_r;

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
         par_r <= STATE_RST;
      else
         par_r <= state_nxt;
   end

   assign O_PARALLEL_STATE_OUT = par_r;
   assign O_PARALLEL_STATE_OE = sync2_r.strobe;

   // ---- checks
   logic [NOTE_CNT_W:0] since_chg_r;

   // helper: cycles of low output since the last change that started or
   // extended the pulse
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
         since_chg_r <= 8'h00;
      else if (changed)
         since_chg_r <= 8'h00;
      else if (O_CHANGE_NOTIFY_OE && since_chg_r != 8'hFF)
         since_chg_r <= since_chg_r + 8'h01;
   end

   AST_GND_OPEN_HIGH: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (!sync2_r.mode[0] && sync2_r.thr[0].gnd_above_hi) |=> state_r[0])
      else $error("ground/open channel not high above upper threshold");

   AST_GND_LOW: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (!sync2_r.mode[1] && sync2_r.thr[1].gnd_below_lo && !sync2_r.thr[1].gnd_above_hi)
      |=> !state_r[1])
      else $error("ground/open channel not low below lower threshold");

   AST_SUP_HIGH: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (sync2_r.mode[2] && sync2_r.thr[2].sup_above_hi) |=> state_r[2])
      else $error("supply/open channel not high above upper threshold");

   AST_SUP_HOLD: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (sync2_r.mode[3] && !sync2_r.thr[3].sup_above_hi && !sync2_r.thr[3].sup_below_lo)
      |=> (state_r[3] == $past(state_r[3])))
      else $error("supply/open channel left its state between thresholds");

   AST_MODE_IGNORES_OTHER: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (sync2_r.mode[0] && sync2_r.thr[0].sup_below_lo && !sync2_r.thr[0].sup_above_hi)
      |=> !state_r[0])
      else $error("supply/open channel not low below lower threshold");

   AST_NOTE_START: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (armed && state_r != prev_r) |=> (O_CHANGE_NOTIFY_OE && !O_CHANGE_NOTIFY_N_O))
      else $error("state change did not pull notification low");

   AST_NOTE_LENGTH: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      $fell(O_CHANGE_NOTIFY_OE) |-> (since_chg_r == 8'(NOTE_PULSE_CYC)))
      else $error("notification low time is not one pulse after last change");

   AST_NOTE_EXTEND: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (O_CHANGE_NOTIFY_OE && changed) |=> O_CHANGE_NOTIFY_OE [*8])
      else $error("change during pulse did not extend it");

   AST_SNAP_FREEZE: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (!sync2_r.cs_n && $past(!sync2_r.cs_n)) |-> $stable(snap_r))
      else $error("snapshot moved while chip select low");

   AST_SNAP_TRACK: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      sync2_r.cs_n |=> (snap_r == $past(state_r)))
      else $error("snapshot did not follow states while idle");

   AST_PAR_FOLLOW: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
      (!sync2_r.mode[3] && sync2_r.thr[3].gnd_above_hi) |=> O_PARALLEL_STATE_OUT[3])
      else $error("parallel output not high for an open ground/open channel");

endmodule

// ---- dv/fcsr_host_model.sv ----
// host serial master model: chip select, serial clock and chain input
module fcsr_host_model
(
   // serial lines toward the device
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   // serial data back from the device
   input wire logic i_so,
   input wire logic i_so_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   logic so_hold;
   wire so_line;

   // a released output shows the inverse of its last value, so it never matches by luck
   always @(negedge i_so_oe)
   begin
      so_hold = ~i_so;
   end
   assign so_line = i_so_oe ? i_so : so_hold;

   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      so_hold = 1'b0;
   end

   // clock stands low outside frames; the whole frame stays under one chip select
   // hp is the half period in ns; the logic is static, so any slower rate is legal
   task automatic xfer(input int n, input int hp, input logic [7:0] si, output logic [7:0] so);
      so = 8'h00;
      o_cs_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++)
      begin
         o_si = si[i];
         #hp o_sck = 1'b1;
         // sampled on the rising edge, away from the falling edge that moves it
         so[i] = so_line;
         #hp o_sck = 1'b0;
      end
      #hp o_cs_n = 1'b1;
      o_si = ~o_si;
      #45;
   endtask
endmodule

// ---- dv/fcsr_top_bench.sv ----
// self-checking bench of the four channel sensor readout
module fcsr_top_bench;
   import fcsr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic srst;
   logic strobe;
   fcsr_thr_t [NUM_CH-1:0] thr;
   logic [NUM_CH-1:0] mode;
   wire sck;
   wire cs_n;
   wire si;
   wire so;
   wire so_oe;
   wire notify_n_o;
   wire notify_oe;
   wire notify_wire;
   wire [NUM_CH-1:0] par;
   wire par_oe;
   int fail_count;
   int comparisons;
   int cyc;
   int n;
   logic [3:0] st;
   logic [3:0] cap;
   logic [7:0] rd;

   // open-drain line with its pull-up
   assign notify_wire = notify_oe ? notify_n_o : 1'b1;

   always #4 clk = ~clk;

   fcsr_top fcsr_top_i (
      .I_CLOCK(clk),
      .I_SRST(srst),
      .I_CHANNEL_THR(thr),
      .I_CHANNEL_MODE_SELECT(mode),
      .I_SCK(sck),
      .I_CS_N(cs_n),
      .I_SI(si),
      .O_SO(so),
      .O_SO_OE(so_oe),
      .I_PARALLEL_STROBE(strobe),
      .O_PARALLEL_STATE_OUT(par),
      .O_PARALLEL_STATE_OE(par_oe),
      .O_CHANGE_NOTIFY_N_O(notify_n_o),
      .O_CHANGE_NOTIFY_OE(notify_oe)
   );

   fcsr_host_model fcsr_host_model_i (
      .o_sck(sck),
      .o_cs_n(cs_n),
      .o_si(si),
      .i_so(so),
      .i_so_oe(so_oe)
   );

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_int(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // v: 1 above upper, 0 below lower, 2 between; the unselected pair reads the opposite
   task automatic set_ch(input int c, input int v);
      logic a;
      logic b;
      a = (v == 1);
      b = (v == 0);
      @(negedge clk);
      thr[c] = mode[c] ? {b, a, a, b} : {a, b, b, a};
      if (v != 2)
         st[c] = a;
   endtask

   // length of the notification low pulse in system cycles
   task automatic pulse(output int len);
      len = 0;
      for (int i = 0; i < 20 && notify_oe !== 1'b1; i++)
         @(negedge clk);
      while (notify_wire === 1'b0 && len < 400)
      begin
         len++;
         @(negedge clk);
      end
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: run did not finish", $time);
         results();
      end
   end

   initial
   begin
      clk = 1'b0;
      srst = 1'b1;
      strobe = 1'b0;
      thr = '0;
      mode = 4'h0;
      fail_count = 0;
      comparisons = 0;
      cyc = 0;
      st = 4'h0;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      repeat (8) @(negedge clk);
      chk({4'h0, par}, 8'h00, "reset states");
      chk({7'h00, notify_oe}, 8'h00, "idle notify");
      chk({7'h00, so_oe}, 8'h00, "idle serial out");
      // both mode patterns, each channel up, held between thresholds, then down
      for (int m = 0; m < 2; m++)
      begin
         mode = m ? 4'h5 : 4'hA;
         for (int v = 1; v >= 0; v--)
            for (int c = 0; c < NUM_CH; c++)
            begin
               set_ch(c, v);
               pulse(n);
               chk_int(n, NOTE_PULSE_CYC, "pulse");
               set_ch(c, 2);
               repeat (6) @(negedge clk);
               chk({4'h0, par}, {4'h0, st}, "states");
            end
      end
      // a second change inside the pulse stretches it
      set_ch(0, 1);
      fork
         pulse(n);
         begin
            repeat (40) @(negedge clk);
            set_ch(2, 1);
         end
      join
      chk_int(n, 41 + NOTE_PULSE_CYC, "merged pulse");
      repeat (10) @(negedge clk);
      // chained read; a change after chip select fall must not reach the frame
      cap = st;
      fork
         fcsr_host_model_i.xfer(8, 15, 8'h0B, rd);
         begin
            #50;
            set_ch(1, 1);
         end
      join
      chk(rd, {4'hB, cap}, "chain read");
      chk({7'h00, so_oe}, 8'h00, "released");
      repeat (200) @(negedge clk);
      // a new frame re-captures instead of showing chained bits
      fork
         fcsr_host_model_i.xfer(4, 50, 8'h0F, rd);
         begin
            #60;
            chk({7'h00, so_oe}, 8'h01, "driven");
         end
      join
      chk(rd, {4'h0, st}, "recapture");
      @(negedge clk);
      strobe = 1'b1;
      repeat (3) @(negedge clk);
      chk({7'h00, par_oe}, 8'h01, "strobe on");
      strobe = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h00, par_oe}, 8'h00, "strobe off");
      results();
   end
endmodule
